/* design/loi_cfg.svh */
// constants for the ladder output instruction unit
// Behaviour
// - direct output writes the execution condition to the addressed contact item.
// - inverted output writes the complement of the execution condition.
// - latch set forces the bit to 1 when condition is 1.
// - latch clear forces the bit to 0 when condition is 1.
// - rising pulse drives target to 1 for one cycle on 0 to 1.
// - falling pulse drives target to 1 for one cycle on 1 to 0.
// - timer op selects timer 0 to 10, counts while condition is 1.
// - end op stops evaluation; later instructions skipped that cycle.
// - idle op changes neither condition nor any contact item.
// - edge pulses cleared at start of next operation cycle.
// - latch set items hold their value until explicitly cleared.
// - instructions evaluated once per operation cycle, 0.1 to 2 s.
// - load begins a logic block, setting condition from a contact.
// - output instructions only target writable contact-input items.
`ifndef LOI_CFG_SVH
`define LOI_CFG_SVH
`define LOI_OP_W 4
`define LOI_OP_LOAD 4'h0
`define LOI_OP_LOAD_NOT 4'h1
`define LOI_OP_OUT 4'h2
`define LOI_OP_OUT_NOT 4'h3
`define LOI_OP_SET 4'h4
`define LOI_OP_CLR 4'h5
`define LOI_OP_RISE 4'h6
`define LOI_OP_FALL 4'h7
`define LOI_OP_TIMER 4'h8
`define LOI_OP_END 4'h9
`define LOI_OP_IDLE 4'ha
`define LOI_TIMER_MAX 4'ha
`define LOI_CLK_HZ 50000000
`define LOI_TICK_MS 100
`define LOI_TICK_CYC ((`LOI_CLK_HZ / 1000) * `LOI_TICK_MS)
`define LOI_PERIOD_TICKS 10
`endif

/* design/loi_pkg.sv */
// types for the ladder output instruction unit
package loi_pkg;
    typedef struct packed {
        logic [3:0] op;
        logic [5:0] item;
    } loi_instr_s;
    typedef struct packed {
        logic [5:0] item;
        logic value;
        logic we;
    } loi_write_s;
endpackage

/* design/loi_program_mem.sv */
// program memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module loi_program_mem #(
    parameter int ADDR_W = 6
) (
    input wire logic clock, // system clock
    input wire logic [ADDR_W-1:0] rd_addr, // read address
    output loi_pkg::loi_instr_s rd_data, // registered read data
    input wire logic wr_en, // program load strobe
    input wire logic [ADDR_W-1:0] wr_addr, // program load address
    input wire loi_pkg::loi_instr_s wr_data // program load word
);
    loi_pkg::loi_instr_s mem [0:(1<<ADDR_W)-1];
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

/* design/loi_unit.sv */
// ladder output instruction interpreter top
`timescale 1ns/100ps
`default_nettype none
`include "loi_cfg.svh"
module loi_unit #(
    parameter int ADDR_W = 6,
    parameter int N_ITEMS = 64,
    parameter int N_TIMERS = 11,
    parameter int TICK_CYC = `LOI_TICK_CYC,
    parameter int PERIOD_TICKS = `LOI_PERIOD_TICKS
) (
    input wire logic clock, // system clock 50 MHz
    input wire logic reset, // async active high
    input wire logic [N_ITEMS-1:0] read_only_mask, // 1 marks contact-output items
    input wire logic [N_ITEMS-1:0] ext_contact, // contact states from other blocks
    input wire logic prog_we, // program load strobe
    input wire logic [ADDR_W-1:0] prog_addr, // program load address
    input wire loi_pkg::loi_instr_s prog_data, // program load word
    output logic [N_ITEMS-1:0] contact_out, // contact item image
    output logic [N_TIMERS*16-1:0] timer_val, // elapsed operation cycles per timer
    output logic cycle_done, // pulse at end of an operation cycle
    output logic busy // evaluation in progress
);
    // ************************************************************
    // operation cycle divider
    // ************************************************************
    logic [31:0] div_reg, div_next;
    logic [7:0] per_reg, per_next;
    logic tick, start;
    always_comb begin
        tick = (div_reg == 32'(TICK_CYC - 1));
        div_next = tick ? 32'h0 : div_reg + 32'h1;
        per_next = per_reg;
        start = 1'b0;
        if (tick) begin
            if (per_reg == 8'(PERIOD_TICKS - 1)) begin
                per_next = 8'h0;
                start = 1'b1;
            end else begin
                per_next = per_reg + 8'h1;
            end
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            div_reg <= 32'h0;
            per_reg <= 8'h0;
        end else begin
            div_reg <= div_next;
            per_reg <= per_next;
        end
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    typedef enum logic [1:0] {LOI_IDLE, LOI_FETCH, LOI_EXEC} loi_state_e;
    loi_state_e st_reg, st_next;
    logic [ADDR_W-1:0] pc_reg, pc_next;
    logic cond_reg, cond_next;
    logic [N_ITEMS-1:0] img_reg, img_next, pulse_reg, pulse_next, prev_reg, prev_next;
    logic [N_TIMERS-1:0] run_reg, run_next;
    logic done_reg, done_next;
    loi_pkg::loi_instr_s ins;
    logic writable;
    loi_program_mem #(.ADDR_W(ADDR_W)) u_mem (
        .clock(clock),
        .rd_addr(pc_reg),
        .rd_data(ins),
        .wr_en(prog_we),
        .wr_addr(prog_addr),
        .wr_data(prog_data)
    );
    always_comb begin
        st_next = st_reg;
        pc_next = pc_reg;
        cond_next = cond_reg;
        img_next = img_reg;
        pulse_next = pulse_reg;
        prev_next = prev_reg;
        run_next = run_reg;
        done_next = 1'b0;
        writable = !read_only_mask[ins.item];
        case (st_reg)
            LOI_IDLE: begin
                if (start) begin
                    img_next = img_reg & ~pulse_reg;
                    pulse_next = '0;
                    pc_next = '0;
                    st_next = LOI_FETCH;
                end
            end
            LOI_FETCH: begin
                st_next = LOI_EXEC;
            end
            LOI_EXEC: begin
                pc_next = pc_reg + ADDR_W'(1);
                st_next = LOI_FETCH;
                case (ins.op)
                    `LOI_OP_LOAD: cond_next = img_reg[ins.item] | ext_contact[ins.item];
                    `LOI_OP_LOAD_NOT: cond_next = !(img_reg[ins.item] | ext_contact[ins.item]);
                    `LOI_OP_OUT: if (writable) img_next[ins.item] = cond_reg;
                    `LOI_OP_OUT_NOT: if (writable) img_next[ins.item] = !cond_reg;
                    `LOI_OP_SET: if (writable && cond_reg) img_next[ins.item] = 1'b1;
                    `LOI_OP_CLR: if (writable && cond_reg) img_next[ins.item] = 1'b0;
                    `LOI_OP_RISE: begin
                        prev_next[ins.item] = cond_reg;
                        if (writable && cond_reg && !prev_reg[ins.item]) begin
                            img_next[ins.item] = 1'b1;
                            pulse_next[ins.item] = 1'b1;
                        end
                    end
                    `LOI_OP_FALL: begin
                        prev_next[ins.item] = cond_reg;
                        if (writable && !cond_reg && prev_reg[ins.item]) begin
                            img_next[ins.item] = 1'b1;
                            pulse_next[ins.item] = 1'b1;
                        end
                    end
                    `LOI_OP_TIMER: begin
                        if (ins.item[3:0] <= `LOI_TIMER_MAX) run_next[ins.item[3:0]] = cond_reg;
                    end
                    `LOI_OP_END: begin
                        st_next = LOI_IDLE;
                        done_next = 1'b1;
                    end
                    default: ; // idle op: condition and image unchanged, pc advances
                endcase
                if (pc_reg == {ADDR_W{1'b1}} && ins.op != `LOI_OP_END) begin
                    st_next = LOI_IDLE;
                    done_next = 1'b1;
                end
            end
            default: st_next = LOI_IDLE;
        endcase
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_reg <= LOI_IDLE;
            pc_reg <= '0;
            cond_reg <= 1'b0;
            img_reg <= '0; // items other than edge pulses hold between cycles
            pulse_reg <= '0;
            prev_reg <= '0;
            run_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            pc_reg <= pc_next;
            cond_reg <= cond_next;
            img_reg <= img_next;
            pulse_reg <= pulse_next;
            prev_reg <= prev_next;
            run_reg <= run_next;
            done_reg <= done_next;
        end
    end

    // ************************************************************
    // timers, counted in operation cycles
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < N_TIMERS; g++) begin : g_tim
            logic [15:0] t_reg, t_next;
            always_comb begin
                t_next = t_reg;
                if (!run_reg[g]) t_next = 16'h0;
                else if (start && t_reg != 16'hffff) t_next = t_reg + 16'h1;
            end
            always_ff @(posedge clock or posedge reset) begin
                if (reset) t_reg <= 16'h0;
                else t_reg <= t_next;
            end
            assign timer_val[g*16 +: 16] = t_reg;
        end
    endgenerate

    assign contact_out = img_reg;
    assign cycle_done = done_reg;
    assign busy = (st_reg != LOI_IDLE);

    // ************************************************************
    // checks
    // ************************************************************
    chk_out_value: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_OUT && writable) |=> img_reg[$past(ins.item)] == $past(cond_reg))
        else $error("direct output value wrong");
    chk_outnot_value: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_OUT_NOT && writable) |=> img_reg[$past(ins.item)] != $past(cond_reg))
        else $error("inverted output value wrong");
    chk_set_latch: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_SET && writable && cond_reg) |=> img_reg[$past(ins.item)])
        else $error("latch set failed");
    chk_clr_latch: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_CLR && writable && cond_reg) |=> !img_reg[$past(ins.item)])
        else $error("latch clear failed");
    chk_pulse_clear: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_IDLE && start) |=> (pulse_reg == '0) && ((img_reg & $past(pulse_reg)) == '0))
        else $error("pulse not cleared at cycle start");
    chk_end_stop: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_END) |=> st_reg == LOI_IDLE && cycle_done)
        else $error("end did not stop evaluation");
    chk_idle_noop: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_IDLE) |=> $stable(img_reg) && $stable(cond_reg))
        else $error("idle op changed state");
    chk_readonly_item: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && !writable && ins.op != `LOI_OP_END) |=> img_reg[$past(ins.item)] == $past(img_reg[ins.item]))
        else $error("read-only item written");
    chk_rise_once: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_RISE && writable && cond_reg && prev_reg[ins.item])
        |=> pulse_reg[$past(ins.item)] == $past(pulse_reg[ins.item]))
        else $error("rise pulse without edge");
    chk_rise_pulse: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_RISE && writable && cond_reg && !prev_reg[ins.item])
        |=> img_reg[$past(ins.item)] && pulse_reg[$past(ins.item)])
        else $error("rise pulse missing");
    chk_fall_pulse: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op == `LOI_OP_FALL && writable && !cond_reg && prev_reg[ins.item])
        |=> img_reg[$past(ins.item)] && pulse_reg[$past(ins.item)])
        else $error("fall pulse missing");
    chk_edge_copy: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && (ins.op == `LOI_OP_RISE || ins.op == `LOI_OP_FALL))
        |=> prev_reg[$past(ins.item)] == $past(cond_reg))
        else $error("edge copy not updated");
    // the last address wraps to idle, so only ordinary steps must advance by one
    chk_pc_advance: assert property (@(posedge clock) disable iff (reset)
        (st_reg == LOI_EXEC && ins.op != `LOI_OP_END && pc_reg != {ADDR_W{1'b1}})
        |=> st_reg == LOI_FETCH && pc_reg == $past(pc_reg) + ADDR_W'(1))
        else $error("instruction order broken");
endmodule
`default_nettype wire

/* verification/loi_partner.sv */
// far-side function block model that feeds and reads contact items
`timescale 1ns/100ps
`default_nettype none
module loi_partner (
    input wire logic clock, // system clock
    input wire logic reset, // async active high
    input wire logic [1:0] drive, // contact states to present
    input wire logic cycle_done, // end of producer cycle
    input wire logic [63:0] contact_out, // producer image
    output logic [63:0] ext_contact, // contact states to producer
    output logic [63:0] seen // image read once per producer cycle
);
    // unused contacts held low so loads of written items see only the image
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ext_contact <= 64'h0;
            seen <= 64'h0;
        end else begin
            ext_contact <= {62'h0, drive};
            // read once per producer cycle, so no pulse is missed
            if (cycle_done) begin
                seen <= contact_out;
            end
        end
    end
endmodule
`default_nettype wire

/* verification/tb_ladder_output_instruction_unit.sv */
// self-checking testbench for the ladder output instruction unit
`timescale 1ns/100ps
`default_nettype none
module tb_ladder_output_instruction_unit;
    localparam int TICK = 20;
    localparam int PER = 4;
    // load0 out10 outn11 set12 load1 clr12 rise13 fall14 tmr2 load10 out15 out40 tmr15 idle16 end set17
    localparam logic [9:0] PROG [16] = '{10'h000, 10'h08a, 10'h0cb, 10'h10c, 10'h001, 10'h14c, 10'h18d,
        10'h1ce, 10'h202, 10'h00a, 10'h08f, 10'h0a8, 10'h20f, 10'h290, 10'h240, 10'h111};
    localparam logic [1:0] CORN [8] = '{2'h0, 2'h3, 2'h3, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic prog_we = 1'b0;
    logic [5:0] prog_addr = 6'h0;
    loi_pkg::loi_instr_s prog_data = '0;
    logic [1:0] drv = 2'h0;
    logic [63:0] ext, contact_out, seen, e;
    logic [175:0] tval;
    logic done, busy, a, b, pb;
    logic [15:0] t;
    logic [7:0] s = 8'h4a;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    int last = -1;

    loi_unit #(.TICK_CYC(TICK), .PERIOD_TICKS(PER)) loi_unit_i (.clock(clock), .reset(reset),
        .read_only_mask(64'h0000_0100_0000_0000), .ext_contact(ext), .prog_we(prog_we),
        .prog_addr(prog_addr), .prog_data(prog_data), .contact_out(contact_out),
        .timer_val(tval), .cycle_done(done), .busy(busy));
    loi_partner loi_partner_i (.clock(clock), .reset(reset), .drive(drv), .cycle_done(done),
        .contact_out(contact_out), .ext_contact(ext), .seen(seen));

    always #10 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // image after one pass of the fixed program
    function automatic logic [63:0] exp_img(input logic [63:0] i, input logic x, y, py);
        logic [63:0] r;
        r = i;
        r[14:13] = {py & ~y, y & ~py};
        r[10] = x;
        r[11] = ~x;
        if (x) r[12] = 1'b1;
        if (y) r[12] = 1'b0;
        r[15] = x;
        return r;
    endfunction

    task automatic results();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic compare(input logic [255:0] got, input logic [255:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait for busy (0) or cycle_done (1)
    task automatic wait_hi(input logic which);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge clock);
            #1;
            if ((which ? done : busy) === 1'b1) break;
        end
        if (i == 400) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            results();
        end
    endtask

    initial begin
        a = 1'b0;
        b = 1'b0;
        pb = 1'b0;
        t = 16'h0;
        e = 64'h0;
        repeat (20) @(posedge clock);
        compare({busy, done, tval, contact_out}, '0);
        reset <= 1'b0;
        for (int k = 0; k < 16; k++) begin
            @(posedge clock);
            prog_we <= 1'b1;
            prog_addr <= k[5:0];
            prog_data <= PROG[k];
        end
        @(posedge clock);
        prog_we <= 1'b0;
        $display("program load done");
        for (int k = 0; k < 40; k++) begin
            wait_hi(1'b0);
            compare(contact_out[14:13], 2'h0);
            wait_hi(1'b1);
            if (last >= 0) compare(cyc - last, TICK * PER);
            last = cyc;
            e = exp_img(e, a, b, pb);
            // counts whole cycles run: the first cycle with the condition set leaves zero
            t = (b && pb) ? t + 16'h1 : 16'h0;
            pb = b;
            @(posedge clock);
            #1;
            compare(seen, e);
            compare(contact_out, e);
            compare(tval, {128'h0, t, 32'h0});
            s = lfsr_next(s);
            {b, a} = k < 8 ? CORN[k] : s[1:0];
            @(posedge clock);
            drv <= {b, a};
            $display("operation cycle %0d done", k);
        end
        results();
    end
endmodule
`default_nettype wire
